// ===== core/pcbt_pkg.sv
/*
 Package for the program counter branch target block: widths, address
 constants and the branch method enumeration.
 Assumes a 16-bit code address space and byte-wide opcodes.
*/
`default_nettype none
package pcbt_pkg;
   localparam int          PC_W          = 16;
   localparam logic [15:0] PC_RESET      = 16'h0000;
   localparam logic [15:0] FIXED_BASE    = 16'h0800;
   localparam logic [15:0] TABLE_BASE    = 16'h0040;
   localparam int          LEN_W         = 3;
   localparam int          DISP_SIGN_BIT = 7;
   localparam int          VEC_LO        = 1;
   localparam int          VEC_HI        = 5;

   typedef enum logic [2:0] {
      PCBT_NONE,
      PCBT_REL_UNCOND,
      PCBT_REL_COND,
      PCBT_ABS,
      PCBT_FIXED,
      PCBT_TABLE,
      PCBT_REGJMP
   } pcbt_kind_t;
endpackage
`default_nettype wire

// ===== core/pcbt_if.sv
/*
 Interface between the counter top and its target adder.
 Assumes both ends run on the same core clock.
*/
`default_nettype none
interface pcbt_if;
   logic [15:0] next_seq;
   logic [7:0]  disp;
   logic [15:0] rel_target;
   modport top (output next_seq, output disp, input rel_target);
   modport add (input next_seq, input disp, output rel_target);
endinterface
`default_nettype wire

// ===== core/pcbt_rel_add.sv
/*
 Relative target adder: sign-extends the displacement and adds it to the
 address of the following instruction.
 Assumes inputs from logic on the same clock; purely combinational.
*/
`default_nettype none
module pcbt_rel_add
   import pcbt_pkg::*;
(
   pcbt_if.add  bus   // Adder side of the carrier
);
   logic [15:0] disp_ext;

   always_comb begin
      disp_ext = {{8{bus.disp[DISP_SIGN_BIT]}}, bus.disp};
      // Carry out of bit 15 is dropped on purpose
      bus.rel_target = 16'(bus.next_seq + disp_ext);
   end
endmodule
`default_nettype wire

// ===== core/pcbt_top.sv
/*
 Program counter update: sequential advance or branch load.
 Assumes the decoder presents one instruction per i_step pulse with its
 length, kind and operands, all on i_core_clk.
*/
`default_nettype none
module pcbt_top
   import pcbt_pkg::*;
(
   input  wire logic             i_core_clk,     // Core clock
   input  wire logic             i_rst,          // Sync reset, high
   input  wire logic             i_step,         // Instruction retire pulse
   input  wire logic [2:0]       i_len,          // Instruction byte count
   input  wire pcbt_pkg::pcbt_kind_t i_kind,     // Branch method
   input  wire logic             i_cond_met,     // Conditional taken
   input  wire logic [7:0]       i_branch_displacement, // Relative disp
   input  wire logic [15:0]      i_imm16,        // Absolute address
   input  wire logic [10:0]      i_imm11,        // Fixed-area address
   input  wire logic [7:0]       i_opcode,       // Opcode for table index
   input  wire logic [15:0]      i_table_data,   // Table word read
   input  wire logic [15:0]      i_accumulator_pair, // Register pair
   output logic [15:0]           o_table_addr,   // Table entry address
   output logic [15:0]           o_pc,           // Program counter
   output logic                  o_branch_taken  // Branch loaded, pulse
);
   import pcbt_pkg::*;

   pcbt_if lnk ();

   logic [15:0] pc_reg;
   logic [15:0] pc_next;
   logic        taken_reg;
   logic        taken_next;
   logic [15:0] seq_addr;
   logic [4:0]  vec_idx;

   pcbt_rel_add u_add (
      .bus (lnk.add)
   );

   // ==========================================================
   // Target selection
   always_comb begin
      seq_addr = 16'(pc_reg + {13'h0000, i_len});
      vec_idx  = i_opcode[VEC_HI:VEC_LO];
      // Entries are byte pairs, so the index steps by two
      o_table_addr = TABLE_BASE | {10'h000, vec_idx, 1'b0};
      lnk.next_seq = seq_addr;
      lnk.disp     = i_branch_displacement;
      pc_next    = pc_reg;
      taken_next = 1'b0;
      if (i_step) begin
         pc_next = seq_addr;
         case (i_kind)
            PCBT_REL_UNCOND: begin
               pc_next    = lnk.rel_target;
               taken_next = 1'b1;
            end
            PCBT_REL_COND: begin
               if (i_cond_met) begin
                  pc_next    = lnk.rel_target;
                  taken_next = 1'b1;
               end
            end
            PCBT_ABS: begin
               pc_next    = i_imm16;
               taken_next = 1'b1;
            end
            PCBT_FIXED: begin
               pc_next    = FIXED_BASE | {5'h00, i_imm11};
               taken_next = 1'b1;
            end
            PCBT_TABLE: begin
               pc_next    = i_table_data;
               taken_next = 1'b1;
            end
            PCBT_REGJMP: begin
               pc_next    = i_accumulator_pair;
               taken_next = 1'b1;
            end
            default: begin
               pc_next = seq_addr;
            end
         endcase
      end
   end

   // ==========================================================
   // State
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         pc_reg    <= PC_RESET;
         taken_reg <= 1'b0;
      end else begin
         pc_reg    <= pc_next;
         taken_reg <= taken_next;
      end
   end

   assign o_pc           = pc_reg;
   assign o_branch_taken = taken_reg;

   // ==========================================================
   // Checks: named sequences
   sequence s_step_kind(pcbt_kind_t k);
      i_step && i_kind == k;
   endsequence

   sequence s_cond_taken;
      i_step && i_kind == PCBT_REL_COND && i_cond_met;
   endsequence

   // Every form that loads a destination instead of the next address
   sequence s_branch_step;
      i_step && (i_kind == PCBT_REL_UNCOND || i_kind == PCBT_ABS
         || i_kind == PCBT_FIXED || i_kind == PCBT_TABLE
         || i_kind == PCBT_REGJMP
         || (i_kind == PCBT_REL_COND && i_cond_met));
   endsequence

   // Jump, then one plain instruction at the destination
   sequence s_abs_then_seq;
      s_step_kind(PCBT_ABS) ##1 s_step_kind(PCBT_NONE);
   endsequence

   // ==========================================================
   // Checks: sequential advance, hold and taken flag
   AST_SEQ_ADV: assert property (@(posedge i_core_clk)
      disable iff (i_rst)
      s_step_kind(PCBT_NONE) |=> o_pc == 16'($past(o_pc) + $past(i_len)))
      else $error("sequential advance wrong");
   AST_SEQ_NO_TAKE: assert property (@(posedge i_core_clk)
      disable iff (i_rst)
      s_step_kind(PCBT_NONE) |=> !o_branch_taken)
      else $error("taken flag on plain step");
   // Codes outside the list fall back to the sequential advance
   AST_UNKNOWN_KIND: assert property (@(posedge i_core_clk)
      disable iff (i_rst)
      i_step && i_kind == pcbt_kind_t'(3'h7)
      |=> o_pc == 16'($past(o_pc) + $past(i_len)) && !o_branch_taken)
      else $error("unknown kind not sequential");
   AST_HOLD: assert property (@(posedge i_core_clk)
      disable iff (i_rst)
      !i_step |=> $stable(o_pc) && !o_branch_taken)
      else $error("pc moved without step");
   AST_TAKEN_SET: assert property (@(posedge i_core_clk)
      disable iff (i_rst)
      s_branch_step |=> o_branch_taken)
      else $error("taken flag missing after branch");
   AST_CONTINUE: assert property (@(posedge i_core_clk)
      disable iff (i_rst)
      s_abs_then_seq |=> o_pc == 16'($past(i_imm16, 2) + $past(i_len)))
      else $error("fetch did not continue at destination");

   // ==========================================================
   // Checks: relative targets
   AST_REL: assert property (@(posedge i_core_clk)
      disable iff (i_rst)
      s_step_kind(PCBT_REL_UNCOND) |=> o_pc == 16'($past(o_pc)
         + $past(i_len) + {{8{$past(i_branch_displacement[7])}},
         $past(i_branch_displacement)}))
      else $error("relative target wrong");
   AST_REL_BACK: assert property (@(posedge i_core_clk)
      disable iff (i_rst)
      s_step_kind(PCBT_REL_UNCOND) ##0 (i_branch_displacement == 8'h80)
      |=> o_pc == 16'($past(o_pc) + $past(i_len) - 16'h0080))
      else $error("negative reach wrong");
   AST_REL_FWD: assert property (@(posedge i_core_clk)
      disable iff (i_rst)
      s_step_kind(PCBT_REL_UNCOND) ##0 (i_branch_displacement == 8'h7f)
      |=> o_pc == 16'($past(o_pc) + $past(i_len) + 16'h007f))
      else $error("positive reach wrong");
   // Offset from the next instruction must lie in -128 to +127
   AST_REL_REACH: assert property (@(posedge i_core_clk)
      disable iff (i_rst)
      s_step_kind(PCBT_REL_UNCOND) |=> 16'(o_pc - $past(o_pc)
         - $past(i_len) + 16'h0080) <= 16'h00ff)
      else $error("relative reach out of range");
   AST_COND: assert property (@(posedge i_core_clk)
      disable iff (i_rst)
      s_step_kind(PCBT_REL_COND) ##0 (!i_cond_met)
      |=> o_pc == 16'($past(o_pc) + $past(i_len)) && !o_branch_taken)
      else $error("untaken branch loaded");
   AST_COND_TAKEN: assert property (@(posedge i_core_clk)
      disable iff (i_rst)
      s_cond_taken |=> o_pc == 16'($past(o_pc) + $past(i_len)
         + {{8{$past(i_branch_displacement[7])}},
         $past(i_branch_displacement)}) && o_branch_taken)
      else $error("taken conditional branch wrong");
   AST_WRAP: assert property (@(posedge i_core_clk)
      disable iff (i_rst)
      s_step_kind(PCBT_REL_UNCOND) ##0 (o_pc == 16'hfffe && i_len == 3'h2
      && i_branch_displacement == 8'h05) |=> o_pc == 16'h0005)
      else $error("wrap wrong");

   // ==========================================================
   // Checks: absolute, fixed-area, table and register forms
   AST_ABS: assert property (@(posedge i_core_clk)
      disable iff (i_rst)
      s_step_kind(PCBT_ABS) |=> o_pc == $past(i_imm16) && o_branch_taken)
      else $error("absolute load wrong");
   AST_FIXED: assert property (@(posedge i_core_clk)
      disable iff (i_rst)
      s_step_kind(PCBT_FIXED) |=> o_pc[15:11] == 5'h01
         && o_pc[10:0] == $past(i_imm11))
      else $error("fixed area target wrong");
   AST_FIXED_WINDOW: assert property (@(posedge i_core_clk)
      disable iff (i_rst)
      s_step_kind(PCBT_FIXED) |=> o_pc >= 16'h0800 && o_pc <= 16'h0fff)
      else $error("fixed area call left its window");
   AST_TABLE: assert property (@(posedge i_core_clk)
      disable iff (i_rst)
      s_step_kind(PCBT_TABLE) |=> o_pc == $past(i_table_data)
         && $past(o_table_addr) >= 16'h0040
         && $past(o_table_addr) <= 16'h007f)
      else $error("table call wrong");
   // Word entries: even address, never past the table
   AST_TABLE_ALIGN: assert property (@(posedge i_core_clk)
      disable iff (i_rst)
      !o_table_addr[0] && o_table_addr[15:6] == 10'h001)
      else $error("table entry address misaligned");
   AST_REGJ: assert property (@(posedge i_core_clk)
      disable iff (i_rst)
      s_step_kind(PCBT_REGJMP) |=> o_pc == $past(i_accumulator_pair))
      else $error("register jump wrong");
endmodule
`default_nettype wire

// ===== sim/pcbt_top_tb_top.sv
/*
 Self-checking bench for the program counter update block.
 Assumes the block's package is compiled first and that the bench
 alone drives every input, with no far-side model.
*/
`default_nettype none
module pcbt_top_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import pcbt_pkg::*;
   logic        i_core_clk, i_rst, i_step, i_cond_met, pending;
   pcbt_kind_t  i_kind;
   logic [2:0]  i_len;
   logic [7:0]  i_branch_displacement, i_opcode;
   logic [10:0] i_imm11;
   logic [15:0] i_imm16, i_table_data, i_accumulator_pair;
   logic [15:0] o_table_addr, o_pc, exp_pc;
   logic        o_branch_taken;
   logic [16:0] exp_q[$];
   logic [16:0] exp_e;
   int          fail_count = 0;
   int          comparisons = 0;
   int          seed;
   pcbt_top dut_u (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_step(i_step),
      .i_len(i_len), .i_kind(i_kind), .i_cond_met(i_cond_met),
      .i_branch_displacement(i_branch_displacement), .i_imm16(i_imm16),
      .i_imm11(i_imm11), .i_opcode(i_opcode), .i_table_data(i_table_data),
      .i_accumulator_pair(i_accumulator_pair), .o_table_addr(o_table_addr),
      .o_pc(o_pc), .o_branch_taken(o_branch_taken));
   // ==========================================================
   // Clock, watchdog, checks
   initial begin
      i_core_clk = 1'b0;
      forever #10 i_core_clk = ~i_core_clk;
   end
   initial begin
      repeat (2000) @(posedge i_core_clk);
      fail_count++;
      tally_and_finish();
   end
   task automatic report(input logic [15:0] e, input logic [15:0] g);
      fail_count++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
   endtask
   task automatic check_pc(input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) report(e, g);
   endtask
   task automatic check_addr(input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) report(e, g);
   endtask
   task automatic check_taken(input logic e, input logic g);
      comparisons++;
      if (g !== e) report({15'h0000, e}, {15'h0000, g});
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // Result lands one edge after the step edge
   always @(posedge i_core_clk) pending <= i_step & ~i_rst;
   always @(negedge i_core_clk) begin
      if (pending) begin
         exp_e = exp_q.pop_front();
         check_pc(exp_e[15:0], o_pc);
         check_taken(exp_e[16], o_branch_taken);
      end else if (!i_rst) begin
         check_taken(1'b0, o_branch_taken);
      end
   end
   // ==========================================================
   // Stimulus
   task automatic do_step(input pcbt_kind_t k, input logic [2:0] len,
                          input logic c, input logic [7:0] d,
                          input logic [15:0] a);
      logic [15:0] seq;
      logic [15:0] tgt;
      logic        tk;
      @(negedge i_core_clk);
      i_step = 1'b1;
      i_kind = k;
      i_len = len;
      i_cond_met = c;
      i_branch_displacement = d;
      // Unused operands random so a wrong source shows up
      i_imm16 = 16'($urandom);
      i_imm11 = 11'($urandom);
      i_opcode = 8'($urandom);
      i_table_data = 16'($urandom);
      i_accumulator_pair = 16'($urandom);
      seq = exp_pc + {13'h0000, len};
      tgt = seq + {{8{d[DISP_SIGN_BIT]}}, d};
      tk = 1'b1;
      case (k)
         PCBT_REL_UNCOND: tk = 1'b1;
         PCBT_REL_COND: if (!c) begin
            tgt = seq;
            tk = 1'b0;
         end
         PCBT_ABS: begin
            i_imm16 = a;
            tgt = a;
         end
         PCBT_FIXED: begin
            i_imm11 = a[10:0];
            tgt = FIXED_BASE | {5'h00, a[10:0]};
         end
         PCBT_TABLE: begin
            i_table_data = a;
            tgt = a;
         end
         PCBT_REGJMP: begin
            i_accumulator_pair = a;
            tgt = a;
         end
         default: begin
            tgt = seq;
            tk = 1'b0;
         end
      endcase
      exp_pc = tgt;
      exp_q.push_back({tk, tgt});
      #1 check_addr({9'h000, 1'b1, i_opcode[5:1], 1'b0}, o_table_addr);
   endtask
   task automatic do_reset();
      @(negedge i_core_clk);
      i_step = 1'b0;
      i_rst = 1'b1;
      repeat (5) @(negedge i_core_clk);
      i_rst = 1'b0;
      exp_pc = PC_RESET;
      check_pc(PC_RESET, o_pc);
   endtask
   initial begin
      {i_step, i_cond_met, i_len, i_branch_displacement, i_opcode} = '0;
      {i_imm11, i_imm16, i_table_data, i_accumulator_pair} = '0;
      i_kind = PCBT_NONE;
      i_rst = 1'b1;
      seed = $urandom(32'h8e386ad2);
      do_reset();
      for (int n = 1; n < 8; n++)
         do_step(PCBT_NONE, 3'(n), 1'b0, 8'h00, 16'h0000);
      $display("test sequential done");
      do_step(PCBT_ABS, 3'd3, 1'b0, 8'h00, 16'hfff0);
      do_step(PCBT_REL_UNCOND, 3'd2, 1'b0, 8'h7f, 16'h0000);
      do_step(PCBT_REL_UNCOND, 3'd2, 1'b0, 8'h80, 16'h0000);
      do_step(PCBT_REL_COND, 3'd2, 1'b1, 8'hf0, 16'h0000);
      do_step(PCBT_REL_COND, 3'd2, 1'b0, 8'h10, 16'h0000);
      do_step(PCBT_FIXED, 3'd3, 1'b0, 8'h00, 16'hffff);
      do_step(PCBT_FIXED, 3'd3, 1'b0, 8'h00, 16'h0000);
      do_step(PCBT_TABLE, 3'd1, 1'b0, 8'h00, 16'habcd);
      do_step(PCBT_REGJMP, 3'd1, 1'b0, 8'h00, 16'h5a5a);
      do_step(PCBT_ABS, 3'd3, 1'b0, 8'h00, 16'h1234);
      do_step(PCBT_NONE, 3'd2, 1'b0, 8'h00, 16'h0000);
      do_step(PCBT_ABS, 3'd3, 1'b0, 8'h00, 16'hfffe);
      do_step(PCBT_REL_UNCOND, 3'd2, 1'b0, 8'h05, 16'h0000);
      $display("test branch kinds done");
      for (int n = 0; n < 200; n++) begin
         do_step(pcbt_kind_t'(3'($urandom)), 3'($urandom_range(1, 4)),
                 1'($urandom), 8'($urandom), 16'($urandom));
      end
      $display("test random stream done");
      do_reset();
      do_step(PCBT_NONE, 3'd4, 1'b0, 8'h00, 16'h0000);
      @(negedge i_core_clk);
      i_step = 1'b0;
      repeat (2) @(negedge i_core_clk);
      $display("test mid-run reset done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
